// ### hw/bic_consts.svh
// Register offsets, field positions, reset values and write masks for the bus interface
`ifndef BIC_CONSTS_SVH
`define BIC_CONSTS_SVH
// -------------------------------------------------------
// Register indices; byte address is four times the index
// -------------------------------------------------------
`define BIC_IDX_UPPER 10'h0A0
`define BIC_IDX_LOWER 10'h0A2
`define BIC_IDX_WIDTH 10'h0B0
// -------------------------------------------------------
// Field positions
// -------------------------------------------------------
`define BIC_F_BLK_HI 14
`define BIC_F_BLK_LO 12
`define BIC_F_DA 7
`define BIC_F_UPPER_DRAM_ENABLE 6
`define BIC_F_R3 3
`define BIC_F_R2 2
`define BIC_F_BOOT 7
`define BIC_F_LOWER_WIDTH_SEL 2
`define BIC_F_MID_WIDTH_SEL 1
`define BIC_F_IO_WIDTH_SEL 0
// -------------------------------------------------------
// Reset values and masks
// -------------------------------------------------------
`define BIC_UPPER_RST 16'hF03B
`define BIC_UPPER_WMASK 16'h70CF
`define BIC_LOWER_RST 16'h0000
`define BIC_LOWER_WMASK 16'h70C7
`define BIC_WIDTH_RST 16'h0000
`define BIC_WIDTH_WMASK 16'h007F
`define BIC_UPPER_BASE 4'h8
`define BIC_IO_TOP 4'h0
`endif

// ### hw/bic_pkg.sv
// Types shared by the bus interface and chip select logic
package bic_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_T3 = 3'b011,
      ST_T4 = 3'b100,
      ST_HOLD = 3'b101
   } bic_state_e;
   typedef struct packed {
      logic io;
      logic write;
      logic fetch;
      logic word;
      logic [19:0] addr;
      logic [15:0] wdata;
   } bic_req_s;
endpackage

// ### hw/bic_top.sv
// External bus cycle engine, chip selects, wait states, bus hold and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "bic_consts.svh"
// Contract
// [R01] 1 MB memory space, separate 64 kB I/O space, distinct read/write cycles
// [R02] I/O cycles drive address bits 19 to 16 low
// [R03] Even bank on low lane, odd bank on high lane, chosen by A0 and high enable
// [R04] Either ready input low stretches the data phase until ready returns
// [R05] Ready mode 1 ignores external ready; 0 requires it plus programmed waits
// [R06] Board keeps both ready inputs high during reset
// [R07] Wait code maps 0..3 directly, then 5, 7, 9, 15; one code per register
// [R08] Hold request grants hold acknowledge at end of T4 or idle
// [R09] While holding, bus outputs float and chip selects drive high
// [R10] Hold request sampled low drops acknowledge and resumes the bus
// [R11] Boot width strap latched at reset; low strap gives 8-bit upper fetches
// [R12] Read-only bit 7 shows latched boot width, 1 means 8-bit
// [R13] Bits 6 to 3 choose serial handshake pin functions
// [R14] Bit 2 selects 8-bit lower region accesses
// [R15] Bit 1 selects 8-bit mid and peripheral region accesses
// [R16] Bit 0 selects 8-bit I/O accesses
// [R17] Upper select active from reset, default window F0000h to FFFFFh
// [R18] Upper select low four cycles without waits; reset wait setting applied
// [R19] Block size code picks upper window base E0000h, C0000h or 80000h
// [R20] With address strap high, disable bit suppresses address phase on upper cycles
// [R21] Upper DRAM enable hands 80000h up to DRAM and disables upper select
// [R22] Lower select inactive until its register is read or written
// [R23] 16-bit transfer to 8-bit region runs two low-lane byte cycles, low first
module bic_top (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_req_valid,
   input wire bic_pkg::bic_req_s core_req,
   output logic core_req_ready,
   output logic core_done,
   output logic [15:0] core_rdata,
   input wire logic [15:0] muxed_addr_data_i,
   output logic [15:0] muxed_addr_data_o,
   output logic muxed_addr_data_oe_n,
   output logic [19:0] addr_o,
   output logic bus_oe_n,
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic write_low_byte_n,
   output logic write_high_byte_n,
   output logic byte_high_enable_n,
   output logic data_enable_out_n,
   output logic io_cycle,
   output logic upper_mem_select_n,
   output logic lower_mem_select_n,
   output logic dram_pin_mode,
   output logic [3:0] serial_hs_sel,
   input wire logic async_ready,
   input wire logic sync_ready,
   input wire logic hold_request,
   output logic hold_ack,
   input wire logic boot_width_strap,
   input wire logic addr_enable_strap
);
   // -------------------------------------------------------
   // Helpers
   // -------------------------------------------------------
   function automatic logic [3:0] wait_of(input logic [2:0] code);
      case (code)
         3'b100: wait_of = 4'h5;
         3'b101: wait_of = 4'h7;
         3'b110: wait_of = 4'h9;
         3'b111: wait_of = 4'hF;
         default: wait_of = {2'b00, code[1:0]};
      endcase
   endfunction
   function automatic logic [3:0] upper_base(input logic [2:0] blk);
      case (blk)
         3'b111: upper_base = 4'hF;
         3'b110: upper_base = 4'hE;
         3'b100: upper_base = 4'hC;
         default: upper_base = 4'h8;
      endcase
   endfunction
   function automatic logic [3:0] lower_top(input logic [2:0] blk);
      case (blk)
         3'b000: lower_top = 4'h0;
         3'b001: lower_top = 4'h1;
         3'b011: lower_top = 4'h3;
         default: lower_top = 4'h7;
      endcase
   endfunction
   // -------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic [15:0] ad_s1_r;
   logic [15:0] ad_s2_r;
   always_ff @(posedge mclk)
   begin
      pin_s1_r <= {hold_request, async_ready, sync_ready, boot_width_strap, addr_enable_strap};
      pin_s2_r <= pin_s1_r;
      ad_s1_r <= muxed_addr_data_i;
      ad_s2_r <= ad_s1_r;
   end
   wire hold_s = pin_s2_r[4];
   wire rdy_s = pin_s2_r[3] & pin_s2_r[2]; // see [R04]
   // -------------------------------------------------------
   // Registers
   // -------------------------------------------------------
   logic [15:0] upper_r;
   logic [15:0] lower_r;
   logic [15:0] width_r;
   logic lower_active_r;
   logic boot8_r;
   logic addr_enable_strap_r;
   wire setup = psel & ~penable & ~pready;
   wire [9:0] idx = paddr[11:2];
   wire hit_up = idx == `BIC_IDX_UPPER;
   wire hit_lo = idx == `BIC_IDX_LOWER;
   wire hit_wd = idx == `BIC_IDX_WIDTH;
   wire mapped = hit_up | hit_lo | hit_wd;
   wire acc = psel & penable & pready;
   wire wr_ok = acc & pwrite & ~pslverr;
   wire [15:0] wd = pwdata[15:0];
   wire [15:0] width_rd = {8'h00, boot8_r, width_r[6:0]}; // see [R12]
   wire [15:0] rd_mux = hit_up ? upper_r : hit_lo ? lower_r : width_rd;
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & mapped & ~pwrite) ? {16'h0000, rd_mux} : 32'h00000000;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         upper_r <= `BIC_UPPER_RST; // see [R17]
         lower_r <= `BIC_LOWER_RST;
         width_r <= `BIC_WIDTH_RST;
         lower_active_r <= 1'b0;
      end
      else
      begin
         if (wr_ok & hit_up)
            upper_r <= (wd & `BIC_UPPER_WMASK) | (`BIC_UPPER_RST & ~`BIC_UPPER_WMASK);
         if (wr_ok & hit_lo)
            lower_r <= wd & `BIC_LOWER_WMASK;
         if (wr_ok & hit_wd)
            width_r <= wd & `BIC_WIDTH_WMASK; // see [R13]
         if (acc & hit_lo)
            lower_active_r <= 1'b1; // see [R22]
      end
   end
   // Straps follow the pins while reset is held, so the last value before release stays
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         boot8_r <= ~pin_s2_r[1]; // see [R11]
         addr_enable_strap_r <= pin_s2_r[0];
      end
   end
   // -------------------------------------------------------
   // Region decode of an incoming request
   // -------------------------------------------------------
   wire udram = upper_r[`BIC_F_UPPER_DRAM_ENABLE];
   wire [3:0] a_top = core_req.addr[19:16];
   wire in_dram = ~core_req.io & udram & (a_top >= `BIC_UPPER_BASE); // see [R21]
   wire in_up = ~core_req.io & ~udram & (a_top >= upper_base(upper_r[14:12])); // see [R19]
   wire in_lo = ~core_req.io & lower_active_r & (a_top <= lower_top(lower_r[14:12]));
   wire in_mid = ~core_req.io & ~in_dram & ~in_up & ~in_lo;
   wire [2:0] up_code = {upper_r[`BIC_F_R3], upper_r[1:0]};
   wire [2:0] lo_code = {1'b0, lower_r[1:0]};
   wire up_sel8 = boot8_r & core_req.fetch;
   // DRAM is always 16 bits wide
   wire narrow = core_req.io ? width_r[`BIC_F_IO_WIDTH_SEL] : // see [R16]
                 in_up ? up_sel8 : // see [R11]
                 in_lo ? width_r[`BIC_F_LOWER_WIDTH_SEL] : // see [R14]
                 in_mid ? width_r[`BIC_F_MID_WIDTH_SEL] : 1'b0; // see [R15]
   wire [3:0] req_waits = in_up ? wait_of(up_code) : in_lo ? wait_of(lo_code) : 4'h0; // see [R07]
   wire req_need = in_up ? ~upper_r[`BIC_F_R2] : in_lo ? ~lower_r[`BIC_F_R2] : 1'b1; // see [R05]
   wire take = core_req_valid & core_req_ready;
   // -------------------------------------------------------
   // Bus cycle state machine
   // -------------------------------------------------------
   bic_pkg::bic_state_e state_r;
   bic_pkg::bic_state_e state_nxt;
   wire at_t1 = state_r == bic_pkg::ST_T1;
   wire at_t2 = state_r == bic_pkg::ST_T2;
   wire at_t3 = state_r == bic_pkg::ST_T3;
   wire at_t4 = state_r == bic_pkg::ST_T4;
   bic_pkg::bic_req_s cur_r;
   logic cur_up_r;
   logic cur_lo_r;
   logic cur_narrow_r;
   logic cur_need_r;
   logic [3:0] cur_waits_r;
   logic split_r;
   logic second_r;
   logic [3:0] wcnt_r;
   logic cap_r;
   logic [7:0] low_byte_r;
   wire ready_ok = ~cur_need_r | rdy_s;
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         bic_pkg::ST_IDLE:
            if (hold_s)
               state_nxt = bic_pkg::ST_HOLD; // see [R08]
            else if (take)
               state_nxt = bic_pkg::ST_T1;
         bic_pkg::ST_T1:
            state_nxt = bic_pkg::ST_T2;
         bic_pkg::ST_T2:
            state_nxt = bic_pkg::ST_T3;
         bic_pkg::ST_T3:
            if (wcnt_r == 4'h0 && ready_ok)
               state_nxt = bic_pkg::ST_T4; // see [R04]
         bic_pkg::ST_T4:
            if (split_r & ~second_r)
               state_nxt = bic_pkg::ST_T1; // see [R23]
            else if (hold_s)
               state_nxt = bic_pkg::ST_HOLD; // see [R08]
            else
               state_nxt = bic_pkg::ST_IDLE;
         bic_pkg::ST_HOLD:
            if (~hold_s)
               state_nxt = bic_pkg::ST_IDLE; // see [R10]
         default:
            state_nxt = bic_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_r <= bic_pkg::ST_IDLE;
         cur_r <= '0;
         cur_up_r <= 1'b0;
         cur_lo_r <= 1'b0;
         cur_narrow_r <= 1'b0;
         cur_need_r <= 1'b0;
         cur_waits_r <= 4'h0;
         split_r <= 1'b0;
         second_r <= 1'b0;
         wcnt_r <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         if (take & state_nxt == bic_pkg::ST_T1)
         begin
            cur_r <= core_req;
            cur_up_r <= in_up;
            cur_lo_r <= in_lo;
            cur_narrow_r <= narrow;
            cur_need_r <= req_need;
            cur_waits_r <= req_waits;
            split_r <= narrow & core_req.word;
            second_r <= 1'b0;
         end
         if (at_t4 && state_nxt == bic_pkg::ST_T1)
         begin
            second_r <= 1'b1;
            cur_r.addr <= cur_r.addr + 20'h00001;
         end
         if (at_t2)
            wcnt_r <= cur_waits_r; // see [R07]
         else if (at_t3 && wcnt_r != 4'h0)
            wcnt_r <= wcnt_r - 4'h1;
      end
   end
   // -------------------------------------------------------
   // Pin stage, one cycle behind the state
   // -------------------------------------------------------
   // The lag keeps every pin on a flip-flop at the cost of one cycle of latency
   wire in_cyc = at_t1 | at_t2 | at_t3 | at_t4;
   wire strobe = at_t2 | at_t3 | at_t4;
   wire hide_addr = addr_enable_strap_r & upper_r[`BIC_F_DA] & cur_up_r; // see [R20]
   wire odd_lane = ~cur_narrow_r & cur_r.addr[0];
   wire both_lane = ~cur_narrow_r & cur_r.word & ~cur_r.addr[0];
   wire [7:0] byte_out = second_r ? cur_r.wdata[15:8] : cur_r.wdata[7:0];
   wire [15:0] wdat = cur_narrow_r ? {8'h00, byte_out} :
                      odd_lane ? {cur_r.wdata[7:0], 8'h00} : cur_r.wdata;
   wire [19:0] pin_addr = cur_r.io ? {`BIC_IO_TOP, cur_r.addr[15:0]} : cur_r.addr; // see [R02]
   wire holding = state_r == bic_pkg::ST_HOLD;
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         muxed_addr_data_o <= 16'h0000;
         muxed_addr_data_oe_n <= 1'b1;
         addr_o <= 20'h00000;
         bus_oe_n <= 1'b0;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         write_low_byte_n <= 1'b1;
         write_high_byte_n <= 1'b1;
         byte_high_enable_n <= 1'b1;
         data_enable_out_n <= 1'b1;
         io_cycle <= 1'b0;
         upper_mem_select_n <= 1'b1;
         lower_mem_select_n <= 1'b1;
         hold_ack <= 1'b0;
      end
      else
      begin
         hold_ack <= holding; // see [R08]
         bus_oe_n <= holding; // see [R09]
         addr_o <= pin_addr; // see [R01]
         io_cycle <= cur_r.io;
         ale <= at_t1;
         muxed_addr_data_o <= at_t1 ? pin_addr[15:0] : wdat;
         muxed_addr_data_oe_n <= holding | ~in_cyc | (at_t1 ? hide_addr : ~cur_r.write);
         rd_n <= ~(strobe & ~cur_r.write);
         wr_n <= ~(strobe & cur_r.write);
         write_low_byte_n <= ~(strobe & cur_r.write & (cur_narrow_r | ~cur_r.addr[0]));
         write_high_byte_n <= ~(strobe & cur_r.write & (odd_lane | both_lane));
         byte_high_enable_n <= ~(in_cyc & (odd_lane | both_lane)); // see [R03]
         data_enable_out_n <= ~strobe;
         upper_mem_select_n <= ~(in_cyc & cur_up_r); // see [R18]
         lower_mem_select_n <= ~(in_cyc & cur_lo_r);
      end
   end
   // -------------------------------------------------------
   // Core handshake and read data
   // -------------------------------------------------------
   // Pins lag one cycle and inputs two, so read data is taken one cycle after T4
   wire [15:0] rd_bus = ad_s2_r;
   wire [15:0] rd_word = cur_narrow_r ? (cur_r.word ? {rd_bus[7:0], low_byte_r} : {8'h00, rd_bus[7:0]}) :
                         odd_lane ? {8'h00, rd_bus[15:8]} : rd_bus;
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         cap_r <= 1'b0;
         low_byte_r <= 8'h00;
         core_done <= 1'b0;
         core_rdata <= 16'h0000;
         core_req_ready <= 1'b0;
         dram_pin_mode <= 1'b0;
         serial_hs_sel <= 4'h0;
      end
      else
      begin
         cap_r <= at_t4;
         if (cap_r & at_t1)
            low_byte_r <= rd_bus[7:0]; // see [R23]
         core_done <= cap_r & ~at_t1;
         if (cap_r & ~at_t1 & ~cur_r.write)
            core_rdata <= rd_word;
         core_req_ready <= state_nxt == bic_pkg::ST_IDLE && !take && !hold_s;
         dram_pin_mode <= udram; // see [R21]
         serial_hs_sel <= width_r[6:3]; // see [R13]
      end
   end
   // -------------------------------------------------------
   // Assertions
   // -------------------------------------------------------
   // The board must hold ready high in reset, so no check looks at ready then
   a_io_top_low: assert property (@(posedge mclk) disable iff (reset) // see [R02]
      (!bus_oe_n && io_cycle && !ale && !rd_n) |-> addr_o[19:16] == 4'h0)
      else $error("I/O cycle drove upper address bits");
   a_hold_float: assert property (@(posedge mclk) disable iff (reset) // see [R09]
      hold_ack |-> (bus_oe_n && muxed_addr_data_oe_n && upper_mem_select_n && lower_mem_select_n))
      else $error("Bus driven during hold");
   a_hold_grant: assert property (@(posedge mclk) disable iff (reset) // see [R08]
      (state_r == bic_pkg::ST_IDLE && hold_s) |=> ##1 hold_ack)
      else $error("Hold not granted from idle");
   a_hold_release: assert property (@(posedge mclk) disable iff (reset) // see [R10]
      (holding && !hold_s) |=> ##1 !hold_ack)
      else $error("Hold acknowledge not released");
   a_wait_count: assert property (@(posedge mclk) disable iff (reset) // see [R07]
      (at_t2 && cur_waits_r == 4'hF) |=> at_t3[*8] ##1 at_t3[*8])
      else $error("Fifteen wait states not inserted");
   a_ready_stall: assert property (@(posedge mclk) disable iff (reset) // see [R04]
      (at_t3 && wcnt_r == 4'h0 && cur_need_r && !rdy_s) |=> at_t3)
      else $error("Cycle ended while not ready");
   a_ready_ignore: assert property (@(posedge mclk) disable iff (reset) // see [R05]
      (at_t3 && wcnt_r == 4'h0 && !cur_need_r) |=> at_t4)
      else $error("Ready not ignored");
   a_upper_four: assert property (@(posedge mclk) disable iff (reset) // see [R18]
      ($fell(upper_mem_select_n) && cur_waits_r == 4'h0 && !cur_need_r && !split_r)
      |-> (!upper_mem_select_n)[*4] ##1 upper_mem_select_n)
      else $error("Upper select width wrong");
   a_lower_idle: assert property (@(posedge mclk) disable iff (reset) // see [R22]
      !lower_active_r |-> ##1 lower_mem_select_n)
      else $error("Lower select before its register was touched");
   a_split_bytes: assert property (@(posedge mclk) disable iff (reset) // see [R23]
      (at_t4 && split_r && !second_r) |=> at_t1 ##1 second_r)
      else $error("Second byte cycle missing");
   a_apb_answer: assert property (@(posedge mclk) disable iff (reset)
      (psel && !penable) |=> pready)
      else $error("APB answer late");
   c_hold: cover property (@(posedge mclk) disable iff (reset) $rose(hold_ack));
   c_split: cover property (@(posedge mclk) disable iff (reset) core_done && split_r);
   c_wait15: cover property (@(posedge mclk) disable iff (reset) at_t3 && wcnt_r == 4'hF);
   c_read: cover property (@(posedge mclk) disable iff (reset) core_done && !cur_r.write);
endmodule // bic_top
`default_nettype wire

// ### test/bic_ext_model.sv
// External memory, ready source and alternate master facing the bus interface
`timescale 1ns/1ps
`default_nettype none
module bic_ext_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [15:0] ad_o,
   input wire logic ad_oe_n,
   input wire logic [19:0] addr_o,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic wlb_n,
   input wire logic whb_n,
   input wire logic [3:0] stall_k,
   input wire logic want_hold,
   output logic [15:0] ad_i,
   output logic async_ready,
   output logic sync_ready,
   output logic hold_request
);
   logic [7:0] mem [0:255];
   logic [7:0] a_r;
   logic [15:0] last_r;
   logic [3:0] scnt_r;
   wire strobe = !rd_n || !wr_n;
   wire [15:0] rd_word = a_r[0] ? {mem[a_r], mem[a_r]} : {mem[a_r | 8'h01], mem[a_r]};
   // A released bus shows the inverse of its last level, never a held copy
   assign ad_i = !ad_oe_n ? ad_o : (!rd_n ? rd_word : ~last_r);
   // Ready drops ahead of the cycle so the synchroniser delay cannot hide the stall
   assign async_ready = reset || stall_k == 4'h0 || (strobe && scnt_r >= stall_k);
   assign sync_ready = 1'b1;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
   always @(posedge mclk)
   begin
      last_r <= reset ? 16'h5A5A : ad_i;
      hold_request <= !reset && want_hold;
      scnt_r <= strobe ? scnt_r + 4'h1 : 4'h0;
      if (ale)
         a_r <= addr_o[7:0];
      if (!wr_n && !wlb_n)
         mem[{a_r[7:1], 1'b0}] <= ad_i[7:0];
      if (!wr_n && !whb_n)
         mem[a_r | 8'h01] <= ad_i[15:8];
   end
endmodule // bic_ext_model
`default_nettype wire

// ### test/tb_bic_top.sv
// Self-checking bench for the bus interface: registers, cycles, waits, hold, widths
`timescale 1ns/1ps
`default_nettype none
module tb_bic_top;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, core_req_valid = 1'b0, want_hold = 1'b0;
   logic boot_width_strap = 1'b1, addr_enable_strap = 1'b1, mon = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   bic_pkg::bic_req_s core_req = '0;
   logic [3:0] stall_k = 4'h0;
   logic [31:0] prdata;
   logic [15:0] core_rdata, ad_o, ad_i, v, wd;
   logic [19:0] addr_o;
   logic [3:0] serial_hs_sel;
   logic pready, pslverr, core_req_ready, core_done, ad_oe_n, bus_oe_n, ale, rd_n, wr_n, wlb_n, whb_n;
   logic io_cycle, upper_mem_select_n, lower_mem_select_n, dram_pin_mode, arl, srl, hreq, hold_ack, io_hi;
   logic [32:0] apb_q[$];
   logic [16:0] core_q[$];
   logic [16:0] ce;
   int fails = 0, total_checks = 0, cyc = 0, ucs_n, lcs_n, ale_n, adr_n, n;
   int wtab[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
   logic [2:0] bsz[4] = '{3'h7, 3'h6, 3'h4, 3'h0};
   logic [3:0] bbase[4] = '{4'hF, 4'hE, 4'hC, 4'h8};
   logic [19:0] wadr[3] = '{20'h00020, 20'h40020, 20'hF0020};
   bic_top DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req_valid(core_req_valid),
      .core_req(core_req), .core_req_ready(core_req_ready), .core_done(core_done), .core_rdata(core_rdata),
      .muxed_addr_data_i(ad_i), .muxed_addr_data_o(ad_o), .muxed_addr_data_oe_n(ad_oe_n), .addr_o(addr_o),
      .bus_oe_n(bus_oe_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .write_low_byte_n(wlb_n),
      .write_high_byte_n(whb_n), .byte_high_enable_n(), .data_enable_out_n(), .io_cycle(io_cycle),
      .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
      .dram_pin_mode(dram_pin_mode), .serial_hs_sel(serial_hs_sel), .async_ready(arl), .sync_ready(srl),
      .hold_request(hreq), .hold_ack(hold_ack), .boot_width_strap(boot_width_strap),
      .addr_enable_strap(addr_enable_strap));
   bic_ext_model mem_side (.mclk(mclk), .reset(reset), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .addr_o(addr_o),
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .wlb_n(wlb_n), .whb_n(whb_n), .stall_k(stall_k),
      .want_hold(want_hold), .ad_i(ad_i), .async_ready(arl), .sync_ready(srl), .hold_request(hreq));
   always #25 mclk = ~mclk;
   // ----------------
   // Shared tasks
   // ----------------
   task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      begin
         total_checks++;
         if (seen !== exp)
         begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tally_and_finish();
      begin
         $display("checks %0d mismatches %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // Straps are held through the whole reset so the synchronised copy is settled at release
   task do_reset(input logic strap);
      begin
         reset <= 1'b1;
         boot_width_strap <= strap;
         addr_enable_strap <= strap;
         repeat (3) @(posedge mclk);
         reset <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [32:0] exp);
      begin
         apb_q.push_back(exp);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {16'h0000, d};
         @(posedge mclk);
         penable <= 1'b1;
         n = 0;
         do @(posedge mclk); while (pready !== 1'b1 && n++ < 20);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task xfer(input logic io, input logic w, input logic f, input logic [19:0] a, input logic [15:0] d,
      input logic rd);
      begin
         core_q.push_back({rd, d});
         ucs_n = 0;
         lcs_n = 0;
         ale_n = 0;
         adr_n = 0;
         io_hi = 1'b0;
         core_req_valid <= 1'b1;
         core_req <= '{io: io, write: w, fetch: f, word: 1'b1, addr: a, wdata: w ? d : 16'h0000};
         n = 0;
         do @(posedge mclk); while (core_req_ready !== 1'b1 && n++ < 50);
         core_req_valid <= 1'b0;
         mon <= 1'b1;
         do @(posedge mclk); while (core_done !== 1'b1 && n++ < 300);
         mon <= 1'b0;
         @(posedge mclk);
      end
   endtask
   // ----------------
   // Watchers
   // ----------------
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         fails++;
         tally_and_finish();
      end
      if (mon)
      begin
         ucs_n += (upper_mem_select_n === 1'b0);
         lcs_n += (lower_mem_select_n === 1'b0);
         ale_n += (ale === 1'b1);
         adr_n += (ale === 1'b1 && ad_oe_n === 1'b0);
         io_hi = io_hi | (io_cycle === 1'b1 && addr_o[19:16] !== 4'h0);
      end
      if (pready === 1'b1)
         chk("apb answer", {pslverr, prdata}, apb_q.pop_front());
      if (core_done === 1'b1)
      begin
         ce = core_q.pop_front();
         if (ce[16])
            chk("core read data", core_rdata, ce[15:0]);
      end
   end
   // ----------------
   // Scenarios
   // ----------------
   initial
   begin
      wd = $urandom(32'h79f53faa);
      do_reset(1'b1);
      apb(0, 12'h280, 0, 33'h0F03B);
      apb(0, 12'h2C0, 0, 33'h0);
      apb(1, 12'h100, 16'h1234, {1'b1, 32'h0});
      xfer(0, 0, 1, 20'hFFFF0, 0, 0);
      chk("reset fetch select", ucs_n, 19);
      chk("reset fetch phases", ale_n, 1);
      $display("test reset state done");
      for (int c = 0; c < 8; c++)
      begin
         v = 16'h7004 | (c[2] ? 16'h0008 : 16'h0000) | c[1:0];
         apb(1, 12'h280, v, 0);
         apb(0, 12'h280, 0, {17'h0, v | 16'h8030});
         xfer(0, 0, 1, 20'hF0000, 0, 0);
         chk("wait code select", ucs_n, 4 + wtab[c]);
      end
      $display("test wait codes done");
      for (int i = 0; i < 4; i++)
      begin
         apb(1, 12'h280, {1'b0, bsz[i], 12'h004}, 0);
         xfer(0, 0, 1, {bbase[i], 16'h0000}, 0, 0);
         chk("window base", ucs_n, 4);
         xfer(0, 0, 1, {bbase[i], 16'h0000} - 20'h2, 0, 0);
         chk("below window", ucs_n, 0);
      end
      stall_k <= 4'h6;
      xfer(0, 0, 1, 20'hF0000, 0, 0);
      chk("ready ignored", ucs_n, 4);
      apb(1, 12'h280, 16'h7000, 0);
      xfer(0, 0, 1, 20'hF0000, 0, 0);
      chk("ready stretch", ucs_n > 4, 1);
      stall_k <= 4'h0;
      $display("test windows and ready done");
      xfer(0, 1, 0, 20'h40020, wd, 0);
      xfer(0, 0, 0, 20'h40020, wd, 1);
      xfer(1, 0, 0, 20'hF0020, wd, 1);
      chk("io high address", io_hi, 0);
      xfer(0, 0, 0, 20'h00020, wd, 1);
      chk("lower idle", lcs_n, 0);
      apb(0, 12'h288, 0, 33'h0);
      apb(1, 12'h2C0, 16'h0007, 0);
      for (int i = 0; i < 3; i++)
      begin
         xfer(i == 2, 0, 0, wadr[i], wd, 1);
         chk("byte cycles", ale_n, 2);
         chk("lower active", lcs_n > 0, i == 0);
      end
      apb(1, 12'h2C0, 16'h0078, 0);
      apb(0, 12'h2C0, 0, 33'h78);
      chk("serial select", serial_hs_sel, 4'hF);
      xfer(0, 0, 0, 20'h00020, wd, 1);
      chk("lower word", ale_n, 1);
      $display("test data and widths done");
      apb(1, 12'h280, 16'h7084, 0);
      xfer(0, 0, 1, 20'hF0000, 0, 0);
      chk("address suppressed", adr_n, 0);
      apb(1, 12'h280, 16'h7044, 0);
      xfer(0, 0, 1, 20'hF0000, 0, 0);
      chk("upper under dram", ucs_n, 0);
      chk("dram pins", dram_pin_mode, 1);
      want_hold <= 1'b1;
      n = 0;
      do @(posedge mclk); while (hold_ack !== 1'b1 && n++ < 20);
      @(posedge mclk);
      chk("hold float", {bus_oe_n, ad_oe_n, upper_mem_select_n, lower_mem_select_n, core_req_ready}, 5'h1E);
      want_hold <= 1'b0;
      n = 0;
      do @(posedge mclk); while (hold_ack !== 1'b0 && n++ < 20);
      @(posedge mclk);
      chk("bus resumed", bus_oe_n, 0);
      $display("test suppression dram hold done");
      do_reset(1'b0);
      apb(0, 12'h2C0, 0, 33'h80);
      apb(1, 12'h280, 16'h7084, 0);
      xfer(0, 0, 1, 20'hFFFF0, 0, 0);
      chk("narrow boot fetch", ale_n, 2);
      chk("address kept", adr_n, 2);
      $display("test narrow boot done");
      tally_and_finish();
   end
endmodule // tb_bic_top
`default_nettype wire
